// ---- verilog/adcs_regs.svh ----
// named field positions, widths, reset values, codes and counts of the sequencer
`ifndef ADCS_REGS_SVH
`define ADCS_REGS_SVH

// first control register fields
`define ADCS_F_START 7
`define ADCS_F_PENDING 6
`define ADCS_F_PD 5
`define ADCS_F_CH_MSB 3
// second control register fields
`define ADCS_S_CH_HI 7
`define ADCS_S_DIV_MSB 2
// pin enable high register width
`define ADCS_PEH_W 2
// widths
`define ADCS_CH_W 5
`define ADCS_DIV_W 3
`define ADCS_PIN_W 10
`define ADCS_RES_W 12
`define ADCS_CNT_W 4
`define ADCS_PRE_W 6
`define ADCS_TICKS_W 5
// reset values
`define ADCS_PD_RESET 1'b1
`define ADCS_CH_RESET 5'h00
`define ADCS_DIV_RESET 3'h0
`define ADCS_BYTE_RESET 8'h00
`define ADCS_RES_RESET 12'h000
// codes and counts
`define ADCS_CONV_CLOCKS 16
`define ADCS_DIV_BY8 3'h3
`define ADCS_DIV_UNDEF 3'h7
`define ADCS_FULL_SCALE 12'hfff

`endif

// ---- verilog/adcs_pkg.sv ----
// types, carriers and helper function of the conversion sequencer
`include "adcs_regs.svh"

package adcs_pkg;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_HOLD,
    PH_CONV
  } adcs_phase_t;

  // software writes: one strobe per register and a shared data byte
  typedef struct packed {
    logic first;
    logic second;
    logic pin_low;
    logic pin_high;
    logic [7:0] data;
  } adcs_wr_t;

  // what software reads back
  typedef struct packed {
    logic [7:0] first;
    logic [7:0] second;
    logic [7:0] pin_low;
    logic [7:0] pin_high;
    logic [7:0] result_low;
    logic [7:0] result_high;
  } adcs_readback_t;

  // control toward the analog converter core and pin muxes
  typedef struct packed {
    logic reset;
    logic power_down;
    logic clk_tick;
    logic [`ADCS_CH_W-1:0] channel;
    logic [`ADCS_PIN_W-1:0] pins;
  } adcs_core_ctl_t;

  typedef struct packed {
    adcs_phase_t phase;
    logic start;
    logic power_down;
    logic [`ADCS_CH_W-1:0] channel;
    logic [`ADCS_DIV_W-1:0] div_sel;
    logic [7:0] pin_low;
    logic [`ADCS_PEH_W-1:0] pin_high;
    logic pending;
    logic flag;
    logic done;
    logic [`ADCS_CNT_W-1:0] cnt;
    logic [`ADCS_RES_W-1:0] result;
  } adcs_state_t;

  typedef struct packed {
    logic [`ADCS_PRE_W-1:0] cnt;
    logic tick;
  } adcs_div_state_t;

  // last prescaler count for a divider code: divide by 2**code, undefined code 7 by 64
  function automatic logic [`ADCS_PRE_W-1:0] adcs_div_last(
    input logic [`ADCS_DIV_W-1:0] sel
  );
    logic [`ADCS_PRE_W:0] one_hot;
    one_hot = '0;
    if (sel == `ADCS_DIV_UNDEF) begin
      // undefined code runs as the slowest defined rate
      one_hot[`ADCS_PRE_W] = 1'b1;
    end else begin
      one_hot[sel] = 1'b1;
    end
    adcs_div_last = one_hot[`ADCS_PRE_W-1:0] - 6'h01;
    if (sel == `ADCS_DIV_UNDEF) begin
      adcs_div_last = '1;
    end
  endfunction

endpackage

// ---- verilog/adcs_clkdiv.sv ----
// converter clock prescaler: one tick per selected converter clock period
`timescale 1ns/1ps
`default_nettype none
`include "adcs_regs.svh"

module adcs_clkdiv
  import adcs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic clr,
  input wire logic [`ADCS_DIV_W-1:0] sel,
  // tick out
  output logic tick
);

  adcs_div_state_t s;
  adcs_div_state_t next_s;
  logic [`ADCS_PRE_W-1:0] last;

  always_comb begin
    last = adcs_div_last(sel);
    next_s = s;
    next_s.tick = 1'b0;
    if (clr) begin
      next_s.cnt = '0;
    end else if (s.cnt >= last) begin
      next_s.cnt = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 6'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

  default clocking @(posedge clk); endclocking
  default disable iff (rst || clr || sel != `ADCS_DIV_BY8);

  property p_div8;
    tick |=> (!tick) [*7] ##1 tick;
  endproperty
  a_div8: assert property (p_div8)
    else $error("divide by eight tick spacing wrong");

endmodule
`default_nettype wire

// ---- verilog/adcs_sequencer.sv ----
// conversion sequencer: control bits, start handling, timing and result
`timescale 1ns/1ps
`default_nettype none
`include "adcs_regs.svh"

// Operation
// - converter powered and usable only while power-down bit is zero.
// - five-bit channel select split over both control registers.
// - ten pin enable bits in low and high registers pick analog pins.
// - writing 0fh to low pin enables makes inputs zero to three analog.
// - writing 00h to first control powers converter and selects input zero.
// - writing 03h to second control selects system clock over eight.
// - interrupt only when global and converter enables are both high.
// - start bit low, high, low again begins a conversion.
// - pending flag low after finish; result registers then valid.
// - conversion lasts exactly sixteen converter clock periods.
// - result twelve bits, full scale fffh, step is reference over 4096.
// - result split into low byte and high bits registers.
// - code transitions offset half step; last one step and half below.
// - converter draws no power while power-down bit is high.
// - start left high holds converter in reset, pending forced high.
// - end of conversion clears pending and sets interrupt flag.
// - divider codes 000 to 110 give divide by 1 to 64.
module adcs_sequencer
  import adcs_pkg::*;
#(
  parameter int CONV_CLOCKS = `ADCS_CONV_CLOCKS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // software register writes
  input wire adcs_wr_t wr,
  // interrupt control bits
  input wire logic global_irq_enable,
  input wire logic conv_irq_enable,
  input wire logic conv_irq_flag_clr,
  // analog core result
  input wire logic [`ADCS_RES_W-1:0] core_result,
  // software read back
  output adcs_readback_t rd,
  output logic conversion_pending,
  output logic conv_irq_flag,
  output logic conv_irq,
  output logic conv_done,
  // analog core and pin control
  output adcs_core_ctl_t core_ctl
);

  if (CONV_CLOCKS < 2 || CONV_CLOCKS > (1 << `ADCS_CNT_W)) begin : g_chk
    $error("CONV_CLOCKS out of range for the conversion counter");
  end

  localparam logic [`ADCS_CNT_W-1:0] CNT_LAST =
    `ADCS_CNT_W'(CONV_CLOCKS - 1);

  adcs_state_t s;
  adcs_state_t next_s;
  logic tick;
  logic div_clr;
  logic start_rise;
  logic start_fall;
  logic wr_start;

  // prescaler restarts with every conversion so the first period is whole
  adcs_clkdiv u_div (
    .clk(clk),
    .rst(rst),
    .clr(div_clr),
    .sel(s.div_sel),
    .tick(tick)
  );

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    wr_start = wr.data[`ADCS_F_START];
    start_rise = wr.first && wr_start && !s.start;
    start_fall = wr.first && !wr_start && s.start;
    div_clr = 1'b0;

    // first control register: start, power down, channel low bits
    if (wr.first) begin
      next_s.start = wr_start;
      next_s.power_down = wr.data[`ADCS_F_PD];
      next_s.channel[`ADCS_F_CH_MSB:0] =
        wr.data[`ADCS_F_CH_MSB:0];
    end
    // second control register: channel top bit, clock divider
    if (wr.second) begin
      next_s.channel[`ADCS_CH_W-1] = wr.data[`ADCS_S_CH_HI];
      next_s.div_sel = wr.data[`ADCS_S_DIV_MSB:0];
    end
    if (wr.pin_low) begin
      next_s.pin_low = wr.data;
    end
    if (wr.pin_high) begin
      next_s.pin_high = wr.data[`ADCS_PEH_W-1:0];
    end

    case (s.phase)
      PH_IDLE: begin
        if (start_rise) begin
          next_s.phase = PH_HOLD;
          next_s.pending = 1'b1;
        end
      end
      PH_HOLD: begin
        next_s.pending = 1'b1;
        if (start_fall) begin
          next_s.phase = PH_CONV;
          next_s.cnt = '0;
          div_clr = 1'b1;
        end
      end
      PH_CONV: begin
        if (start_rise) begin
          // restart: back to held reset, count discarded
          next_s.phase = PH_HOLD;
          next_s.cnt = '0;
        end else if (tick && !s.power_down) begin
          if (s.cnt == CNT_LAST) begin
            next_s.phase = PH_IDLE;
            next_s.pending = 1'b0;
            next_s.done = 1'b1;
            // codes taken as the quantiser makes them
            next_s.result = core_result;
          end else begin
            next_s.cnt = s.cnt + 4'h1;
          end
        end
      end
      default: begin
        next_s.phase = PH_IDLE;
      end
    endcase

    // a completion in the same cycle as a clear keeps the flag set
    if (conv_irq_flag_clr) begin
      next_s.flag = 1'b0;
    end
    if (next_s.done) begin
      next_s.flag = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s.phase <= PH_IDLE;
      s.start <= 1'b0;
      s.power_down <= `ADCS_PD_RESET;
      s.channel <= `ADCS_CH_RESET;
      s.div_sel <= `ADCS_DIV_RESET;
      s.pin_low <= `ADCS_BYTE_RESET;
      s.pin_high <= '0;
      s.pending <= 1'b0;
      s.flag <= 1'b0;
      s.done <= 1'b0;
      s.cnt <= '0;
      s.result <= `ADCS_RES_RESET;
    end else begin
      s <= next_s;
    end
  end

  // read back
  always_comb begin
    rd = '0;
    rd.first[`ADCS_F_START] = s.start;
    rd.first[`ADCS_F_PENDING] = s.pending;
    rd.first[`ADCS_F_PD] = s.power_down;
    rd.first[`ADCS_F_CH_MSB:0] = s.channel[`ADCS_F_CH_MSB:0];
    rd.second[`ADCS_S_CH_HI] = s.channel[`ADCS_CH_W-1];
    rd.second[`ADCS_S_DIV_MSB:0] = s.div_sel;
    rd.pin_low = s.pin_low;
    rd.pin_high[`ADCS_PEH_W-1:0] = s.pin_high;
    rd.result_low = s.result[7:0];
    rd.result_high[`ADCS_RES_W-9:0] = s.result[`ADCS_RES_W-1:8];
  end

  assign conversion_pending = s.pending;
  assign conv_irq_flag = s.flag;
  assign conv_irq = s.flag && global_irq_enable && conv_irq_enable;
  assign conv_done = s.done;

  // core control
  always_comb begin
    core_ctl.reset = (s.phase != PH_CONV);
    core_ctl.power_down = s.power_down;
    core_ctl.clk_tick = tick && !s.power_down;
    core_ctl.channel = s.channel;
    core_ctl.pins = {s.pin_high, s.pin_low};
  end

  // checking helpers: ticks seen in the running conversion
  logic [`ADCS_TICKS_W-1:0] ticks_seen;
  always_ff @(posedge clk) begin
    if (rst || s.phase != PH_CONV) begin
      ticks_seen <= '0;
    end else if (tick && !s.power_down) begin
      ticks_seen <= ticks_seen + 5'h01;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_rise_pending;
    (s.phase == PH_IDLE && start_rise) |=> conversion_pending
      && core_ctl.reset;
  endproperty
  a_rise_pending: assert property (p_rise_pending)
    else $error("start raise did not force pending and reset");

  property p_hold;
    s.start |-> conversion_pending && core_ctl.reset
      && s.phase != PH_CONV;
  endproperty
  a_hold: assert property (p_hold)
    else $error("start held high but converter not held");

  property p_begin;
    (s.phase == PH_HOLD && start_fall) |=> s.phase == PH_CONV
      && !core_ctl.reset && s.cnt == '0;
  endproperty
  a_begin: assert property (p_begin)
    else $error("start sequence did not begin conversion");

  property p_sixteen;
    conv_done |-> $past(ticks_seen) == 5'(CONV_CLOCKS - 1);
  endproperty
  a_sixteen: assert property (p_sixteen)
    else $error("conversion length not sixteen converter clocks");

  property p_end_flags;
    conv_done |-> !conversion_pending && conv_irq_flag
      && s.phase == PH_IDLE;
  endproperty
  a_end_flags: assert property (p_end_flags)
    else $error("end of conversion flags wrong");

  property p_result_split;
    $rose(conv_done) |-> rd.result_low == $past(core_result[7:0])
      && rd.result_high[3:0] == $past(core_result[11:8])
      && rd.result_high[7:4] == 4'h0;
  endproperty
  a_result_split: assert property (p_result_split)
    else $error("result bytes do not match converted value");

  property p_result_hold;
    !next_s.done |=> $stable(s.result);
  endproperty
  a_result_hold: assert property (p_result_hold)
    else $error("result changed without a completion");

  property p_irq_gate;
    conv_irq |-> global_irq_enable && conv_irq_enable && conv_irq_flag;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt raised without both enables");

  property p_pd_stall;
    (s.power_down && s.phase == PH_CONV && !start_rise) |=>
      $stable(s.cnt) && !conv_done;
  endproperty
  a_pd_stall: assert property (p_pd_stall)
    else $error("conversion advanced while powered down");

  property p_flag_sticky;
    (conv_irq_flag && !conv_irq_flag_clr) |=> conv_irq_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("interrupt flag cleared without software clear");

  property p_restart;
    (s.phase == PH_CONV && start_rise) |=> s.phase == PH_HOLD
      && conversion_pending ##1 !conv_done;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart did not abort running conversion");

  // a falling start with no raise before it must leave the sequencer idle
  property p_idle_quiet;
    (s.phase == PH_IDLE && !start_rise) |=> s.phase == PH_IDLE
      && !conversion_pending;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("conversion began without a start raise");

  property p_busy_pending;
    s.phase != PH_IDLE |-> conversion_pending;
  endproperty
  a_busy_pending: assert property (p_busy_pending)
    else $error("pending low while a conversion is held or running");

  property p_done_pulse;
    conv_done |=> !conv_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("completion pulse longer than one cycle");

endmodule
`default_nettype wire

// ---- testbench/adcs_core_model.sv ----
// analog core stand-in: counts converter ticks, shows result at the last one
`timescale 1ns/1ps
`default_nettype none
`include "adcs_regs.svh"

module adcs_core_model
  import adcs_pkg::*;
(
  // clock
  input wire logic clk,
  // control from the sequencer and value to convert
  input wire adcs_core_ctl_t ctl,
  input wire logic [`ADCS_RES_W-1:0] sample,
  // result toward the sequencer
  output logic [`ADCS_RES_W-1:0] result
);
  int ticks = 0;
  logic [`ADCS_RES_W-1:0] junk = 12'h5a5;

  always @(posedge clk) begin
    junk <= ~junk ^ 12'h0c3;
    if (ctl.reset) begin
      ticks <= 0;
    end else if (ctl.clk_tick) begin
      ticks <= ticks + 1;
    end
  end

  // valid only on the completing tick, a changing pattern otherwise
  assign result = (!ctl.reset && ctl.clk_tick &&
    ticks == `ADCS_CONV_CLOCKS - 1) ? sample : junk;
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
`include "adcs_regs.svh"

module tb_top;
  import adcs_pkg::*;
  typedef struct {logic [11:0] res; longint t; int lat;} adcs_note_t;
  logic clk, rst, gie, cie, fclr, pending, flag, irq, done;
  logic [11:0] sample, core_result, last;
  adcs_wr_t wr;
  adcs_readback_t rd;
  adcs_core_ctl_t ctl;
  adcs_note_t q[$];
  adcs_note_t n;
  longint t_take, t0, ta;
  int error_cnt = 0;
  int check_count = 0;

  adcs_sequencer uut (.clk(clk), .rst(rst), .wr(wr),
    .global_irq_enable(gie), .conv_irq_enable(cie),
    .conv_irq_flag_clr(fclr), .core_result(core_result), .rd(rd),
    .conversion_pending(pending), .conv_irq_flag(flag), .conv_irq(irq),
    .conv_done(done), .core_ctl(ctl));
  adcs_core_model core (.clk(clk), .ctl(ctl), .sample(sample),
    .result(core_result));

  task automatic chk(input logic [47:0] got, exp, input string m);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // one write strobe; records the edge that takes it
  task automatic wr_reg(input int r, input logic [7:0] d);
    @(posedge clk);
    wr <= '{(r == 0), (r == 1), (r == 2), (r == 3), d};
    @(posedge clk);
    t_take = $time;
    wr <= '0;
  endtask

  task automatic convert(input logic [11:0] s, input int lat);
    sample <= s;
    last = s;
    wr_reg(0, 8'h80);
    wr_reg(0, 8'h00);
    q.push_back('{s, t_take, lat});
  endtask

  task automatic drain;
    int k = 0;
    // completion is found by polling pending, interrupts may stay off
    while ((q.size() != 0 || pending !== 1'b0) && k < 3000) begin
      @(posedge clk);
      k++;
    end
    chk(q.size(), 0, "conversion did not finish");
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // completion monitor against the oldest note
  always @(negedge clk) begin
    if (!rst && done === 1'b1) begin
      if (q.size() == 0) begin
        error_cnt++;
        $display("wrong value at %0t: completion not expected", $time);
      end else begin
        n = q.pop_front();
        chk(($time - 5 - n.t) / 10, n.lat, "latency");
        chk({rd.result_high, rd.result_low}, {4'h0, n.res}, "result");
        chk({pending, flag}, 2'b01, "pending and flag");
      end
    end
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #(20000 * 10);
    error_cnt++;
    $display("wrong value at %0t: watchdog expired", $time);
    end_of_test();
  end

  initial begin
    rst = 1'b1;
    wr = '0;
    gie = 1'b0;
    cie = 1'b0;
    fclr = 1'b0;
    sample = '0;
    void'($urandom(32'h8286));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(rd, {8'h20, 40'h0}, "reset readback");
    chk({ctl.reset, ctl.power_down}, 2'b11, "reset core ctl");
    wr_reg(1, 8'h83);
    wr_reg(0, 8'h0a);
    wr_reg(3, 8'h03);
    wr_reg(2, 8'h0f);
    @(posedge clk);
    #1;
    chk(ctl.channel, 5'h1a, "channel split");
    chk({ctl.pins, rd.pin_high, rd.pin_low}, {10'h30f, 8'h03, 8'h0f},
      "pins");
    wr_reg(1, 8'h03);
    wr_reg(0, 8'h00);
    wr_reg(3, 8'h00);
    @(posedge clk);
    #1;
    chk({rd.first, rd.second, ctl.channel, ctl.power_down},
      {8'h00, 8'h03, 5'h0, 1'b0}, "setup");
    for (int c = 0; c < 8; c++) begin
      wr_reg(1, {5'h0, c[2:0]});
      convert(c == 7 ? 12'hfff : 12'($urandom),
        16 * (1 << (c == 7 ? 6 : c)) + 1);
      drain();
    end
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      gie <= k[0];
      cie <= k[1];
      #1;
      chk({flag, irq}, {1'b1, k == 3}, "irq gating");
    end
    @(posedge clk);
    fclr <= 1'b1;
    @(posedge clk);
    fclr <= 1'b0;
    #1;
    chk({flag, irq}, 2'b00, "flag clear");
    wr_reg(1, 8'h00);
    wr_reg(0, 8'h80);
    wr_reg(0, 8'h00);
    repeat (5) @(posedge clk);
    convert(12'($urandom), 17);
    drain();
    wr_reg(0, 8'h80);
    repeat (40) @(posedge clk);
    #1;
    chk({pending, ctl.reset}, 2'b11, "start held high");
    convert(12'($urandom), 17);
    drain();
    last = 12'($urandom);
    sample <= last;
    wr_reg(0, 8'h80);
    wr_reg(0, 8'h00);
    t0 = t_take;
    repeat (3) @(posedge clk);
    wr_reg(0, 8'h20);
    ta = t_take;
    repeat (4) @(posedge clk);
    #1;
    chk({ctl.clk_tick, pending}, 2'b01, "stalled while off");
    wr_reg(0, 8'h00);
    q.push_back('{last, t0, 17 + int'((t_take - ta) / 10)});
    drain();
    sample <= 12'($urandom);
    repeat (20) @(posedge clk);
    #1;
    chk({rd.result_high, rd.result_low}, {4'h0, last}, "held");
    end_of_test();
  end
endmodule
`default_nettype wire
